// ===== hw/pmw_power_mode_fsm.sv
/*
  operating mode sequencer: reset, lockout, fuse read, normal, low power,
  polling, io supply check and low power hold, with wake sources and fault gating.
  assumes an spi block on the same clock supplies commands and settings;
  supply, pin and comparator levels arrive asynchronously and are synchronised.
*/
`timescale 1ns/1ps
// Summary of operation
// - below core threshold: reset, nothing active
// - lockout: keep state, refuse spi, outputs off
// - lockout runs both oscillators
// - supply rises: fuse read, then normal
// - normal accepts commands; host programs low power
// - wake_out_n driven low in normal
// - fault detection runs in normal
// - low power only by command
// - low power: fast clock off, faults off
// - settings kept through low power
// - listed events wake to normal
// - pin edges wake only with io_supply
// - interrupt timer expiry interrupts and wakes
// - poll each period for poll_active_time
// - timer beats coinciding poll
// - open-and-still-open inputs stop polling
// - low supply in low power: hold
// - poll end: wake on change else sleep
// - comparator-only inputs watched continuously
// - no wake enables: stop poll timer
// - threshold meaning per switch type
// - power-on reset: defaults, flag set
// - supply low mid-word: drop, lock out
// - lockout seen flag after recovery
module pmw_power_mode_fsm #(
  parameter int FUSE_CYC = pmw_pkg::FUSE_READ_CYC
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             porActive,
  input  wire logic                             supplyLow,
  input  wire logic                             ioSupplyOk,
  input  wire logic                             chipSelectN,
  input  wire logic                             intNIn,
  input  wire logic                             wakeOutNIn,
  input  wire logic [pmw_pkg::NUM_IN-1:0]       compAbove,
  input  wire logic                             cmdEnterLowPower,
  input  wire logic [pmw_pkg::TMR_W-1:0]        intTimerPeriod,
  input  wire logic [pmw_pkg::TMR_W-1:0]        pollTimerPeriod,
  input  wire logic [pmw_pkg::NUM_IN-1:0]       wakeEnable,
  input  wire logic [pmw_pkg::NUM_IN-1:0]       compOnly,
  input  wire logic [pmw_pkg::NUM_PROG-1:0]     batterySwitchCfg,
  input  wire logic                             wakePinWakeEn,
  input  wire logic                             spiBusy,
  input  wire logic [pmw_pkg::NUM_FAULT-1:0]    faultIn,
  input  wire logic [pmw_pkg::NUM_FAULT-1:0]    faultClr,
  input  wire logic                             porSeenClr,
  input  wire logic                             lockoutSeenClr,
  input  wire logic                             wakeClr,
  input  wire logic                             intAck,
  output pmw_pkg::pmw_state_t                   modeState,
  output logic                                  oscFastEn,
  output logic                                  oscSlowEn,
  output logic                                  spiAccept,
  output logic                                  misoEnable,
  output logic                                  muxEnable,
  output logic                                  faultDetectEn,
  output logic                                  regsToDefault,
  output logic                                  spiWordAbort,
  output logic [pmw_pkg::NUM_IN-1:0]            currentSrcEn,
  output logic [pmw_pkg::NUM_IN-1:0]            switchClosed,
  output logic [pmw_pkg::NUM_FAULT-1:0]         faultStatus,
  output logic                                  porSeen,
  output logic                                  lockoutSeen,
  output pmw_pkg::pmw_wake_t                    wakeSource,
  output logic                                  wakeOutNo,
  output logic                                  wakeOutNOeN,
  output logic                                  intNOut,
  output logic                                  intNOeN
);
  import pmw_pkg::*;

  // switch reading of one input from its comparator
  function automatic logic closedOf(input logic above, input logic battSw);
    return battSw ? above : !above;
  endfunction : closedOf

  logic [SYNC_W-1:0]    syncS;
  logic                 porS, uvS, ioS, csS, intS, wakeS;
  logic [NUM_IN-1:0]    aboveS;
  logic [NUM_IN-1:0]    closedNow;
  logic [NUM_IN-1:0]    battMap;
  pmw_state_t           state_q, state_d;
  pmw_wake_t            wake_d, edgeSrc_q, edgeSrc_d, wakeSrc_q;
  logic [CNT_W-1:0]     cnt_q;
  logic [NUM_IN-1:0]    snap_q, pollMask_q, closed_q;
  logic [NUM_FAULT-1:0] fault_q;
  logic                 porSeen_q, lockoutSeen_q, intReq_q;
  logic                 csPrev_q, intPrev_q, wakePrev_q;
  logic                 intTick, pollTick;

  pmw_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({compAbove, wakeOutNIn, intNIn, chipSelectN, ioSupplyOk, supplyLow, porActive}),
    .dout (syncS)
  );

  assign {aboveS, wakeS, intS, csS, ioS, uvS, porS} = syncS;
  assign battMap = {batterySwitchCfg, {NUM_GND{1'b0}}};

  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_read
      assign closedNow[g] = closedOf(aboveS[g], battMap[g]);
    end
  endgenerate

  // state decodes
  wire inReset  = (state_q == ST_RESET);
  wire inLock   = (state_q == ST_LOCKOUT);
  wire inFuse   = (state_q == ST_FUSE);
  wire inNormal = (state_q == ST_NORMAL);
  wire inLow    = (state_q == ST_LOWPWR);
  wire inPoll   = (state_q == ST_POLL);
  wire inIoChk  = (state_q == ST_IOCHK);
  wire sleeping = inLow || inPoll;

  wire anyWakeEn = |wakeEnable;
  wire csFall    = csPrev_q && !csS;
  wire intFall   = intPrev_q && !intS;
  wire wakeFall  = wakePrev_q && !wakeS && wakePinWakeEn;
  wire pinEdge   = csFall || intFall || wakeFall;
  wire [NUM_IN-1:0] changed = closed_q ^ snap_q;
  wire compWake  = |(changed & compOnly & wakeEnable);
  wire pollWake  = |(changed & pollMask_q);
  wire fuseDone  = (cnt_q == CNT_W'(FUSE_CYC - 1));
  wire pollDone  = (cnt_q == CNT_W'(POLL_ACTIVE_CYC - 1));
  wire pollTrim  = inPoll && (cnt_q == CNT_W'(POLL_SETTLE_CYC - 1));
  wire [NUM_IN-1:0] openBoth = ~snap_q & ~closed_q;

  pmw_timer u_int_timer (
    .clk    (clk),
    .rst    (rst),
    .run    (sleeping),
    .period (intTimerPeriod),
    .tick   (intTick)
  );

  pmw_timer u_poll_timer (
    .clk    (clk),
    .rst    (rst),
    .run    (inLow && anyWakeEn),
    .period (pollTimerPeriod),
    .tick   (pollTick)
  );

  always_comb begin
    state_d   = state_q;
    wake_d    = WK_NONE;
    edgeSrc_d = edgeSrc_q;
    if (pinEdge) begin
      edgeSrc_d = csFall ? WK_CSPIN : (intFall ? WK_INTPIN : WK_WAKEPIN);
    end
    case (state_q)
      ST_RESET: begin
        if (!porS) state_d = ST_LOCKOUT;
      end
      ST_LOCKOUT: begin
        if (!uvS) state_d = ST_FUSE;
      end
      ST_FUSE: begin
        if (uvS) state_d = ST_LOCKOUT;
        else if (fuseDone) state_d = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (uvS) state_d = ST_LOCKOUT;
        else if (cmdEnterLowPower) state_d = ST_LOWPWR;
      end
      ST_LOWPWR, ST_POLL: begin
        if (uvS) begin
          state_d = ST_LPHOLD;
        end else if (intTick) begin
          state_d = ST_NORMAL;
          wake_d  = WK_TIMER;
        end else if (compWake) begin
          state_d = ST_NORMAL;
          wake_d  = WK_INPUT;
        end else if (pinEdge) begin
          state_d = ST_IOCHK;
        end else if (inLow && pollTick) begin
          state_d = ST_POLL;
        end else if (inPoll && pollDone) begin
          state_d = pollWake ? ST_NORMAL : ST_LOWPWR;
          wake_d  = pollWake ? WK_INPUT : WK_NONE;
        end
      end
      ST_IOCHK: begin
        state_d = ioS ? ST_NORMAL : ST_LOWPWR;
        wake_d  = ioS ? edgeSrc_q : WK_NONE;
      end
      ST_LPHOLD: begin
        if (!uvS) state_d = ST_LOWPWR;
      end
      default: state_d = ST_RESET;
    endcase
    if (porS) begin
      state_d = ST_RESET;
      wake_d  = WK_NONE;
    end
  end

  wire stateChange = (state_d != state_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= ST_RESET;
      cnt_q      <= '0;
      edgeSrc_q  <= WK_NONE;
      csPrev_q   <= 1'b1;
      intPrev_q  <= 1'b1;
      wakePrev_q <= 1'b1;
      closed_q   <= MASK_RST;
    end else begin
      state_q    <= state_d;
      cnt_q      <= stateChange ? '0 : cnt_q + CNT_W'(1);
      edgeSrc_q  <= edgeSrc_d;
      csPrev_q   <= csS;
      intPrev_q  <= intS;
      wakePrev_q <= wakeS;
      closed_q   <= closedNow;
    end
  end

  // entry snapshot and polling current mask
  always_ff @(posedge clk) begin
    if (rst || inReset) begin
      snap_q     <= MASK_RST;
      pollMask_q <= MASK_RST;
    end else begin
      if (inNormal && state_d == ST_LOWPWR) snap_q <= closed_q;
      if (state_d == ST_POLL && !inPoll) pollMask_q <= wakeEnable & ~compOnly;
      else if (pollTrim) pollMask_q <= pollMask_q & ~openBoth;
    end
  end

  // status flags: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst || inReset) begin
      fault_q       <= FAULT_RST;
      porSeen_q     <= !rst && state_d != ST_RESET;
      lockoutSeen_q <= 1'b0;
      wakeSrc_q     <= WK_NONE;
      intReq_q      <= 1'b0;
    end else begin
      fault_q       <= (fault_q & ~faultClr) | (inNormal ? faultIn : '0);
      porSeen_q     <= porSeen_q && !porSeenClr;
      lockoutSeen_q <= (lockoutSeen_q && !lockoutSeenClr) || (inLock && !uvS);
      if (wake_d != WK_NONE) wakeSrc_q <= wake_d;
      else if (wakeClr) wakeSrc_q <= WK_NONE;
      intReq_q      <= (intReq_q && !intAck) || (wake_d == WK_TIMER);
    end
  end

  assign porSeen       = porSeen_q;
  assign modeState     = state_q;
  assign oscFastEn     = inLock || inFuse || inNormal;
  assign oscSlowEn     = !inReset;
  assign spiAccept     = inNormal;
  assign misoEnable    = inNormal;
  assign muxEnable     = inNormal;
  assign faultDetectEn = inNormal;
  assign regsToDefault = inReset;
  assign spiWordAbort  = inNormal && uvS && spiBusy;
  assign currentSrcEn  = inNormal ? {NUM_IN{1'b1}} : (inPoll ? pollMask_q : MASK_RST);
  assign switchClosed  = closed_q;
  assign faultStatus   = fault_q;
  assign lockoutSeen   = lockoutSeen_q;
  assign wakeSource    = wakeSrc_q;
  assign wakeOutNo     = 1'b0;
  assign wakeOutNOeN   = !inNormal;
  assign intNOut       = 1'b0;
  assign intNOeN       = !intReq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_reset_quiet;
    inReset |-> !oscSlowEn && !oscFastEn && !spiAccept && currentSrcEn == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("activity while in reset");

  property p_lockout_off;
    inLock |-> !spiAccept && !misoEnable && !muxEnable && currentSrcEn == '0;
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("lockout outputs not off");

  property p_lockout_osc;
    inLock |-> oscFastEn && oscSlowEn;
  endproperty
  a_lockout_osc: assert property (p_lockout_osc) else $error("oscillators off in lockout");

  property p_fuse_exit;
    inFuse && fuseDone && !uvS && !porS |=> state_q == ST_NORMAL;
  endproperty
  a_fuse_exit: assert property (p_fuse_exit) else $error("fuse read did not end in normal");

  property p_wake_pin;
    inNormal |-> !wakeOutNOeN && !wakeOutNo;
  endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("wake line not driven in normal");

  property p_lp_entry;
    inNormal && cmdEnterLowPower && !uvS && !porS |=> state_q == ST_LOWPWR;
  endproperty
  a_lp_entry: assert property (p_lp_entry) else $error("command did not enter low power");

  property p_no_fault_rec;
    !inNormal && faultClr == '0 && !inReset && !rst |=> faultStatus == $past(faultStatus);
  endproperty
  a_no_fault_rec: assert property (p_no_fault_rec) else $error("fault recorded outside normal");

  property p_io_low;
    inIoChk && !ioS && !porS |=> state_q == ST_LOWPWR ##0 wakeSource == $past(wakeSource);
  endproperty
  a_io_low: assert property (p_io_low) else $error("wake reported without io supply");

  property p_coincide;
    inLow && intTick && pollTick && !uvS && !porS |=> state_q == ST_NORMAL && wakeSource == WK_TIMER;
  endproperty
  a_coincide: assert property (p_coincide) else $error("poll taken over timer expiry");

  property p_hold;
    state_q == ST_LPHOLD && uvS && !porS |=> state_q == ST_LPHOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("woke during low supply");

  c_poll_wake: cover property (inPoll && pollDone && pollWake);
  c_cs_wake:   cover property (inIoChk && ioS && edgeSrc_q == WK_CSPIN);
  c_timer:     cover property (sleeping && intTick);
endmodule : pmw_power_mode_fsm

// ===== hw/pmw_sync.sv
/*
  two flip-flop synchroniser, one lane per bit.
  assumes lanes are independent levels; reset values come from the package.
*/
`timescale 1ns/1ps
module pmw_sync (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [pmw_pkg::SYNC_W-1:0]    din,
  output logic      [pmw_pkg::SYNC_W-1:0]    dout
);
  import pmw_pkg::*;

  logic [SYNC_W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_lane
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q[i] <= SYNC_RST[i];
          dout[i]   <= SYNC_RST[i];
        end else begin
          meta_q[i] <= din[i];
          dout[i]   <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule : pmw_sync

// ===== hw/pmw_timer.sv
/*
  periodic wake timer: tick every period cycles while run is high.
  assumes a period of zero means the timer is off; dropping run restarts it.
*/
`timescale 1ns/1ps
module pmw_timer (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        run,
  input  wire logic [pmw_pkg::TMR_W-1:0]   period,
  output logic                             tick
);
  import pmw_pkg::*;

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;
  wire              active = run && (period != '0);

  assign tick  = active && (cnt_q == period - TMR_W'(1));
  assign cnt_d = (!active || tick) ? '0 : cnt_q + TMR_W'(1);

  always_ff @(posedge clk) begin
    if (rst) cnt_q <= '0;
    else     cnt_q <= cnt_d;
  end
endmodule : pmw_timer

// ===== include/pmw_pkg.sv
/*
  shared constants and types of the power mode, wake and poll sequencer.
  assumes a 125 MHz core clock; times are derived to cycle counts here.
*/
package pmw_pkg;
  localparam int NUM_GND   = 14;
  localparam int NUM_PROG  = 8;
  localparam int NUM_IN    = 22;
  localparam int NUM_FAULT = 5;
  localparam int TMR_W     = 16;
  localparam int CNT_W     = 13;
  localparam int CLK_MHZ   = 125;

  // fault bit positions
  localparam int FLT_OVERVOLT = 0;
  localparam int FLT_OVERHEAT = 1;
  localparam int FLT_THERMWRN = 2;
  localparam int FLT_SPI      = 3;
  localparam int FLT_HASH     = 4;

  // times as printed, then cycles
  localparam int FUSE_READ_US    = 50;
  localparam int FUSE_READ_CYC   = FUSE_READ_US * CLK_MHZ;
  localparam int POLL_ACTIVE_US  = 20;
  localparam int POLL_ACTIVE_CYC = POLL_ACTIVE_US * CLK_MHZ;
  localparam int POLL_SETTLE_NS  = 1000;
  localparam int POLL_SETTLE_CYC = (POLL_SETTLE_NS * CLK_MHZ + 999) / 1000;

  // synchroniser lanes: por, supply low, io ok, cs_n, int_n, wake_n, comparators
  localparam int                SYNC_W   = 6 + NUM_IN;
  localparam logic [SYNC_W-1:0] SYNC_RST = 28'h000003b;

  localparam logic [NUM_FAULT-1:0] FAULT_RST = 5'h00;
  localparam logic [NUM_IN-1:0]    MASK_RST  = 22'h000000;

  typedef enum logic [2:0] {
    ST_RESET, ST_LOCKOUT, ST_FUSE, ST_NORMAL, ST_LOWPWR, ST_POLL, ST_IOCHK, ST_LPHOLD
  } pmw_state_t;

  typedef enum logic [2:0] {
    WK_NONE, WK_INPUT, WK_TIMER, WK_WAKEPIN, WK_INTPIN, WK_CSPIN
  } pmw_wake_t;
endpackage : pmw_pkg

// ===== tb/pmw_host_model.sv
/*
  host side of the sequencer: sends the enter-low-power command and pulls
  chip select, interrupt and wake lines low on request.
  assumes open-drain lines with pull-ups; the bench asks for each action.
*/
`timescale 1ns/1ps
module pmw_host_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sleepReq,
  input  wire logic [2:0] pinReq,
  input  wire logic       misoEnable,
  input  wire logic       intNOut,
  input  wire logic       intNOeN,
  input  wire logic       wakeOutNo,
  input  wire logic       wakeOutNOeN,
  output logic            cmdEnterLowPower,
  output logic            chipSelectN,
  output logic            intNLine,
  output logic            wakeLine,
  output logic            misoTrusted
);
  logic [2:0] pullN_q;
  logic [2:0] cnt_q;
  logic       dropFirst_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      pullN_q <= 3'h7;
      cnt_q   <= 3'h0;
    end else if (|pinReq) begin
      pullN_q <= ~pinReq;
      cnt_q   <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end else begin
      pullN_q <= 3'h7;
    end
  end
  // command only while the device talks, settings already held
  always_ff @(posedge clk) begin
    cmdEnterLowPower <= !rst && sleepReq && misoEnable;
  end
  // replies after a chip select wake are thrown away until the next sleep request
  always_ff @(posedge clk) begin
    if (rst || sleepReq) dropFirst_q <= 1'b0;
    else if (pinReq[0]) dropFirst_q <= 1'b1;
  end
  assign misoTrusted = misoEnable && !dropFirst_q;
  assign chipSelectN = pullN_q[0];
  assign intNLine    = pullN_q[1] & (intNOeN | intNOut);
  assign wakeLine    = pullN_q[2] & (wakeOutNOeN | wakeOutNo);
endmodule : pmw_host_model

// ===== tb/power_mode_wake_poll_fsm_test.sv
/*
  self-checking bench of the mode sequencer with random inputs and corners.
  assumes the host model drives command and pins; short fuse count.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module power_mode_wake_poll_fsm_test;
  import pmw_pkg::*;
  localparam int FC = 20;
  logic clk = 1'b0, rst = 1'b1, porActive = 1'b0, supplyLow = 1'b1, ioSupplyOk = 1'b1;
  logic [NUM_IN-1:0] compAbove = '0, wakeEnable = '0, compOnly = '0, closedAtEntry;
  logic [TMR_W-1:0] intTimerPeriod = '0, pollTimerPeriod = '0;
  logic [NUM_PROG-1:0] batterySwitchCfg = '0;
  logic [NUM_FAULT-1:0] faultIn = '0, faultClr = '0, fv;
  logic spiBusy = 1'b0, intAck = 1'b0, sleepReq = 1'b0, zero = 1'b0, wakePinEn = 1'b1;
  logic [2:0] pinReq = 3'h0;
  logic cmdEnterLowPower, chipSelectN, intNLine, wakeLine, misoTrusted;
  logic oscFastEn, oscSlowEn, spiAccept, misoEnable, muxEnable, faultDetectEn, regsToDefault;
  logic spiWordAbort, porSeen, lockoutSeen, wakeOutNo, wakeOutNOeN, intNOut, intNOeN, sawPoll;
  logic [NUM_IN-1:0] currentSrcEn, switchClosed;
  logic [NUM_FAULT-1:0] faultStatus;
  pmw_state_t modeState;
  pmw_wake_t wakeSource, lastSrc;
  pmw_wake_t pinSrc [3] = '{WK_CSPIN, WK_INTPIN, WK_WAKEPIN};
  int failures = 0, samples_checked = 0, n, k;
  always #4 clk = ~clk;
  pmw_host_model i_pmw_host_model (.clk(clk), .rst(rst), .sleepReq(sleepReq), .pinReq(pinReq),
    .misoEnable(misoEnable), .intNOut(intNOut), .intNOeN(intNOeN), .wakeOutNo(wakeOutNo),
    .wakeOutNOeN(wakeOutNOeN), .cmdEnterLowPower(cmdEnterLowPower), .chipSelectN(chipSelectN),
    .intNLine(intNLine), .wakeLine(wakeLine), .misoTrusted(misoTrusted));
  pmw_power_mode_fsm #(.FUSE_CYC(FC)) i_pmw_power_mode_fsm (.clk(clk), .rst(rst),
    .porActive(porActive), .supplyLow(supplyLow), .ioSupplyOk(ioSupplyOk), .chipSelectN(chipSelectN),
    .intNIn(intNLine), .wakeOutNIn(wakeLine), .compAbove(compAbove), .cmdEnterLowPower(cmdEnterLowPower),
    .intTimerPeriod(intTimerPeriod), .pollTimerPeriod(pollTimerPeriod), .wakeEnable(wakeEnable),
    .compOnly(compOnly), .batterySwitchCfg(batterySwitchCfg), .wakePinWakeEn(wakePinEn), .spiBusy(spiBusy),
    .faultIn(faultIn), .faultClr(faultClr), .porSeenClr(zero), .lockoutSeenClr(zero), .wakeClr(zero),
    .intAck(intAck), .modeState(modeState), .oscFastEn(oscFastEn), .oscSlowEn(oscSlowEn),
    .spiAccept(spiAccept), .misoEnable(misoEnable), .muxEnable(muxEnable), .faultDetectEn(faultDetectEn),
    .regsToDefault(regsToDefault), .spiWordAbort(spiWordAbort), .currentSrcEn(currentSrcEn),
    .switchClosed(switchClosed), .faultStatus(faultStatus), .porSeen(porSeen), .lockoutSeen(lockoutSeen),
    .wakeSource(wakeSource), .wakeOutNo(wakeOutNo), .wakeOutNOeN(wakeOutNOeN), .intNOut(intNOut),
    .intNOeN(intNOeN));
  function automatic logic [NUM_IN-1:0] expClosed(logic [NUM_IN-1:0] a, logic [NUM_PROG-1:0] c);
    expClosed = ~a;
    expClosed[NUM_IN-1:NUM_GND] = ~a[NUM_IN-1:NUM_GND] ^ c;
  endfunction : expClosed
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  task automatic waitState(input pmw_state_t st, input int maxCyc);
    n = 0;
    while (modeState !== st && n < maxCyc) begin
      @(posedge clk);
      #1;
      n++;
      if (modeState === ST_POLL) sawPoll = 1'b1;
    end
  endtask : waitState
  task automatic sleep();
    tick(1);
    sleepReq <= 1'b1;
    tick(1);
    sleepReq <= 1'b0;
    closedAtEntry = expClosed(compAbove, batterySwitchCfg);
    sawPoll = 1'b0;
    waitState(ST_LOWPWR, 5);
    `CHK("lowpower", ST_LOWPWR, modeState)
    `CHK("fastosc", 1'b0, oscFastEn)
    `CHK("faultdet", 1'b0, faultDetectEn)
  endtask : sleep
  task automatic pin(input int p);
    tick(1);
    pinReq <= 3'h1 << p;
    tick(1);
    pinReq <= 3'h0;
  endtask : pin
  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #480000;
    failures++;
    wrap_up();
  end
  initial begin
    void'($urandom(26));
    tick(2);
    rst <= 1'b0;
    #1;
    `CHK("resetstate", ST_RESET, modeState)
    `CHK("defaults", 1'b1, regsToDefault)
    waitState(ST_LOCKOUT, 10);
    `CHK("lockout", ST_LOCKOUT, modeState)
    `CHK("spi", 3'h0, {spiAccept, misoEnable, muxEnable})
    `CHK("sources", '0, currentSrcEn)
    `CHK("oscs", 2'h3, {oscFastEn, oscSlowEn})
    tick(1);
    supplyLow <= 1'b0;
    waitState(ST_FUSE, 10);
    waitState(ST_NORMAL, FC + 10);
    `CHK("fusecycles", FC, n)
    `CHK("flags", 2'h3, {porSeen, lockoutSeen})
    `CHK("wakeline", 2'h0, {wakeOutNOeN, wakeOutNo})
    `CHK("normal", 2'h3, {spiAccept, faultDetectEn})
    fv = 5'($urandom) | 5'h01;
    tick(1);
    faultIn <= fv;
    tick(1);
    faultIn <= '0;
    tick(2);
    #1;
    `CHK("faults", fv, faultStatus)
    tick(1);
    faultClr <= '1;
    tick(1);
    faultClr <= '0;
    repeat (6) begin
      tick(1);
      compAbove <= 22'($urandom);
      batterySwitchCfg <= 8'($urandom);
      tick(5);
      #1;
      `CHK("switch", expClosed(compAbove, batterySwitchCfg), switchClosed)
    end
    sleep();
    tick(1);
    faultIn <= '1;
    tick(3);
    faultIn <= '0;
    lastSrc = wakeSource;
    for (k = 0; k < 3; k++) begin
      tick(1);
      ioSupplyOk <= 1'b0;
      tick(4);
      pin(k);
      tick(20);
      #1;
      `CHK("iolow", ST_LOWPWR, modeState)
      `CHK("nowake", lastSrc, wakeSource)
      tick(1);
      ioSupplyOk <= 1'b1;
      tick(4);
      pin(k);
      waitState(ST_NORMAL, 20);
      `CHK("pinwake", pinSrc[k], wakeSource)
      `CHK("lpfaults", 5'h00, faultStatus)
      lastSrc = wakeSource;
      sleep();
    end
    tick(1);
    wakePinEn <= 1'b0;
    pin(2);
    tick(20);
    #1;
    `CHK("wakecfg", ST_LOWPWR, modeState)
    tick(1);
    wakePinEn <= 1'b1;
    tick(1);
    intTimerPeriod <= 16'h00c8;
    waitState(ST_NORMAL, 400);
    `CHK("timerwake", WK_TIMER, wakeSource)
    `CHK("intline", 1'b0, intNOeN)
    tick(1);
    intAck <= 1'b1;
    tick(1);
    intAck <= 1'b0;
    wakeEnable <= 22'($urandom) | 22'h1;
    intTimerPeriod <= 16'h012c;
    pollTimerPeriod <= 16'h012c;
    sleep();
    waitState(ST_NORMAL, 700);
    `CHK("coincide", {1'b0, WK_TIMER}, {sawPoll, wakeSource})
    tick(1);
    intAck <= 1'b1;
    intTimerPeriod <= '0;
    tick(1);
    intAck <= 1'b0;
    sleep();
    waitState(ST_POLL, 400);
    tick(2);
    #1;
    `CHK("pollsrc", wakeEnable & ~compOnly, currentSrcEn)
    tick(POLL_SETTLE_CYC + 5);
    #1;
    `CHK("trimmed", wakeEnable & ~compOnly & closedAtEntry, currentSrcEn)
    waitState(ST_LOWPWR, POLL_ACTIVE_CYC + 20);
    `CHK("pollend", {1'b1, ST_LOWPWR}, {n > POLL_ACTIVE_CYC - 200, modeState})
    tick(1);
    compAbove <= compAbove ^ (wakeEnable & -wakeEnable);
    waitState(ST_NORMAL, 3300);
    `CHK("pollwake", WK_INPUT, wakeSource)
    k = $urandom_range(NUM_IN - 1);
    tick(1);
    pollTimerPeriod <= '0;
    wakeEnable <= 22'h1 << k;
    compOnly <= 22'h1 << k;
    sleep();
    tick(20);
    compAbove[k] <= ~compAbove[k];
    waitState(ST_NORMAL, 20);
    `CHK("componly", {ST_NORMAL, WK_INPUT}, {modeState, wakeSource})
    tick(1);
    wakeEnable <= '0;
    compOnly <= '0;
    pollTimerPeriod <= 16'h0032;
    sleep();
    waitState(ST_NORMAL, 400);
    `CHK("nopoll", {1'b0, ST_LOWPWR}, {sawPoll, modeState})
    tick(1);
    supplyLow <= 1'b1;
    tick(100);
    #1;
    `CHK("lphold", ST_LPHOLD, modeState)
    tick(1);
    supplyLow <= 1'b0;
    waitState(ST_LOWPWR, 10);
    `CHK("lpresume", ST_LOWPWR, modeState)
    pin(0);
    waitState(ST_NORMAL, 20);
    tick(1);
    spiBusy <= 1'b1;
    tick(2);
    supplyLow <= 1'b1;
    for (n = 0; n < 10 && spiWordAbort !== 1'b1; n++) @(negedge clk);
    `CHK("abort", {1'b1, ST_NORMAL}, {spiWordAbort, modeState})
    tick(1);
    #1;
    `CHK("abortlock", ST_LOCKOUT, modeState)
    tick(1);
    spiBusy <= 1'b0;
    supplyLow <= 1'b0;
    porActive <= 1'b1;
    waitState(ST_RESET, 10);
    tick(1);
    #1;
    `CHK("por", {ST_RESET, 2'h0}, {modeState, lockoutSeen, porSeen})
    tick(1);
    porActive <= 1'b0;
    waitState(ST_NORMAL, FC + 20);
    `CHK("porflag", 1'b1, porSeen)
    wrap_up();
  end
endmodule : power_mode_wake_poll_fsm_test
